/* verilog/timer_map.svh */
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// register indices, byte address is four times the index
`define RUN_FLAG_IDX    10'h088
`define MODE_IDX        10'h089
`define LOW_ZERO_IDX    10'h08a
`define HIGH_ZERO_IDX   10'h08b
`define LOW_ONE_IDX     10'h08c
`define HIGH_ONE_IDX    10'h08d

// reset values
`define MODE_RESET      8'h00
`define RUN_FLAG_RESET  8'h00
`define COUNT_RESET     8'h00

// mode register fields, timer 1 upper nibble, timer 0 lower nibble
`define GATE_ONE_BIT    7
`define SEL_ONE_BIT     6
`define MODE_ONE_HI     5
`define MODE_ONE_LO     4
`define GATE_ZERO_BIT   3
`define SEL_ZERO_BIT    2
`define MODE_ZERO_HI    1
`define MODE_ZERO_LO    0

// run/flag register fields
`define FLAG_ONE_BIT    7
`define RUN_ONE_BIT     6
`define FLAG_ZERO_BIT   5
`define RUN_ZERO_BIT    4

// low-byte bits used as prescaler in the 13-bit mode
`define PRESCALE_BITS   5

// one machine cycle per aclk edge, in oscillator periods
`define MACHINE_CYCLE_OSC 12

// bus answers
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

/* verilog/timer_pkg.sv */
`default_nettype none

package timer_pkg;

   // two-bit mode field codes
   typedef enum logic [1:0] {
      MODE_PRESCALE = 2'b00,
      MODE_FULL     = 2'b01,
      MODE_RELOAD   = 2'b10,
      MODE_SPLIT    = 2'b11
   } timer_mode_type;

   typedef logic [7:0] count_byte_type;

endpackage

`default_nettype wire

/* verilog/pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module pin_sync (
   input  wire logic aclk,    // machine-cycle clock
   input  wire logic aresetn, // synchronous reset, active low
   input  wire logic pin,     // asynchronous pin
   output logic      level,   // synchronised level
   output logic      fall     // high sample then low sample
);

   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // two flops before any logic, third keeps the previous sample
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= pin;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign level = sync_reg;
   assign fall  = last_reg & ~sync_reg;

endmodule

`default_nettype wire

/* verilog/count_step.sv */
`timescale 1ns/10ps
`default_nettype none
`include "timer_map.svh"

module count_step
   import timer_pkg::*;
(
   input  wire timer_mode_type  mode,    // selected mode
   input  wire count_byte_type  lo,      // current low byte
   input  wire count_byte_type  hi,      // current high byte
   input  wire logic            inc_lo,  // count step for low path
   input  wire logic            inc_hi,  // count step for split high byte
   output count_byte_type       lo_next, // low byte after step
   output count_byte_type       hi_next, // high byte after step
   output logic                 ovf_lo,  // overflow of main/low counter
   output logic                 ovf_hi   // overflow of split high byte
);

   logic [13:0] sum13;
   logic [16:0] sum16;
   logic [8:0]  lo_inc;
   logic [8:0]  hi_inc;

   // carries out of each counter width
   assign sum13  = {1'b0, hi, lo[`PRESCALE_BITS-1:0]} + 14'h1;
   assign sum16  = {1'b0, hi, lo} + 17'h1;
   assign lo_inc = {1'b0, lo} + 9'h1;
   assign hi_inc = {1'b0, hi} + 9'h1;

   // next count per mode
   always_comb begin
      lo_next = lo;
      hi_next = hi;
      ovf_lo  = 1'b0;
      ovf_hi  = 1'b0;
      unique case (mode)
         MODE_PRESCALE: begin
            if (inc_lo) begin
               // upper three low bits just keep what they hold
               lo_next = {lo[7:`PRESCALE_BITS], sum13[`PRESCALE_BITS-1:0]};
               hi_next = sum13[12:`PRESCALE_BITS];
               ovf_lo  = sum13[13];
            end
         end
         MODE_FULL: begin
            if (inc_lo) begin
               hi_next = sum16[15:8];
               lo_next = sum16[7:0];
               ovf_lo  = sum16[16];
            end
         end
         MODE_RELOAD: begin
            if (inc_lo) begin
               if (lo_inc[8]) begin
                  lo_next = hi;
                  ovf_lo  = 1'b1;
               end else begin
                  lo_next = lo_inc[7:0];
               end
            end
         end
         MODE_SPLIT: begin
            if (inc_lo) begin
               lo_next = lo_inc[7:0];
               ovf_lo  = lo_inc[8];
            end
            if (inc_hi) begin
               hi_next = hi_inc[7:0];
               ovf_hi  = hi_inc[8];
            end
         end
      endcase
   end

endmodule

`default_nettype wire

/* verilog/timer_pair.sv */
`timescale 1ns/10ps
`default_nettype none
`include "timer_map.svh"

module timer_pair
   import timer_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input  wire logic              aclk,           // machine-cycle clock
   input  wire logic              aresetn,        // synchronous reset, low
   input  wire logic [ADDR_W-1:0] awaddr,         // write address
   input  wire logic [2:0]        awprot,         // unused protection
   input  wire logic              awvalid,        // write address valid
   output logic                   awready,        // write address ready
   input  wire logic [31:0]       wdata,          // write data
   input  wire logic [3:0]        wstrb,          // byte enables
   input  wire logic              wvalid,         // write data valid
   output logic                   wready,         // write data ready
   output logic [1:0]             bresp,          // write response
   output logic                   bvalid,         // write response valid
   input  wire logic              bready,         // write response ready
   input  wire logic [ADDR_W-1:0] araddr,         // read address
   input  wire logic [2:0]        arprot,         // unused protection
   input  wire logic              arvalid,        // read address valid
   output logic                   arready,        // read address ready
   output logic [31:0]            rdata,          // read data
   output logic [1:0]             rresp,          // read response
   output logic                   rvalid,         // read data valid
   input  wire logic              rready,         // read data ready
   input  wire logic              count_pin_zero, // timer 0 event pin
   input  wire logic              count_pin_one,  // timer 1 event pin
   input  wire logic              gate_pin_zero,  // timer 0 gate pin
   input  wire logic              gate_pin_one,   // timer 1 gate pin
   input  wire logic              vector_ack_zero, // cpu vectors, timer 0
   input  wire logic              vector_ack_one, // cpu vectors, timer 1
   output logic                   irq_zero,       // timer 0 request
   output logic                   irq_one,        // timer 1 request
   output logic                   baud_tick       // timer 1 overflow pulse
);

   // the decode uses address bits 11:2
   if (ADDR_W < 12) begin : g_addr_check
      $error("timer_pair needs ADDR_W of at least 12");
   end

   // bus side state
   logic              awready_reg;
   logic              wready_reg;
   logic              bvalid_reg;
   logic [1:0]        bresp_reg;
   logic              arready_reg;
   logic              rvalid_reg;
   logic [1:0]        rresp_reg;
   logic [31:0]       rdata_reg;
   logic              aw_got_reg;
   logic              w_got_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic [7:0]        w_byte_reg;
   logic              w_lane_reg;

   // timer state
   logic [7:0]        timer_mode_reg;
   logic              run_bit_zero_reg;
   logic              run_bit_one_reg;
   logic              overflow_flag_zero_reg;
   logic              overflow_flag_one_reg;
   count_byte_type    low_byte_zero_reg;
   count_byte_type    high_byte_zero_reg;
   count_byte_type    low_byte_one_reg;
   count_byte_type    high_byte_one_reg;
   logic              baud_tick_reg;

   // decode and counting terms
   logic              wr_fire;
   logic [9:0]        wr_idx;
   logic              wr_mapped;
   logic              wr_take;
   logic [9:0]        rd_idx;
   logic [7:0]        rd_byte;
   logic              rd_mapped;
   logic [7:0]        timer_run_flag_reg;
   timer_mode_type    mode_zero;
   timer_mode_type    mode_one;
   logic              gate_lvl_zero;
   logic              gate_lvl_one;
   logic              fall_zero;
   logic              fall_one;
   logic              inc_zero;
   logic              inc_zero_hi;
   logic              inc_one;
   logic              split_zero;
   count_byte_type    lo_zero_next;
   count_byte_type    hi_zero_next;
   count_byte_type    lo_one_next;
   count_byte_type    hi_one_next;
   logic              ovf_zero_lo;
   logic              ovf_zero_hi;
   logic              ovf_one_lo;
   logic              set_flag_zero;
   logic              set_flag_one;

   // pins pass two flops before use
   pin_sync u_count_zero (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     (count_pin_zero),
      .level   (),
      .fall    (fall_zero)
   );

   pin_sync u_count_one (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     (count_pin_one),
      .level   (),
      .fall    (fall_one)
   );

   pin_sync u_gate_zero (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     (gate_pin_zero),
      .level   (gate_lvl_zero),
      .fall    ()
   );

   pin_sync u_gate_one (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     (gate_pin_one),
      .level   (gate_lvl_one),
      .fall    ()
   );

   // write address channel, one write at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b0;
         aw_got_reg  <= 1'b0;
         aw_addr_reg <= '0;
      end else begin
         awready_reg <= awvalid & ~awready_reg & ~aw_got_reg & ~bvalid_reg;
         if (awvalid && awready_reg) begin
            aw_got_reg  <= 1'b1;
            aw_addr_reg <= awaddr;
         end else if (wr_fire) begin
            aw_got_reg  <= 1'b0;
         end
      end
   end

   // write data channel, only byte lane 0 carries register bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_reg <= 1'b0;
         w_got_reg  <= 1'b0;
         w_byte_reg <= 8'h00;
         w_lane_reg <= 1'b0;
      end else begin
         wready_reg <= wvalid & ~wready_reg & ~w_got_reg & ~bvalid_reg;
         if (wvalid && wready_reg) begin
            w_got_reg  <= 1'b1;
            w_byte_reg <= wdata[7:0];
            w_lane_reg <= wstrb[0];
         end else if (wr_fire) begin
            w_got_reg  <= 1'b0;
         end
      end
   end

   // the write takes effect once both halves are in
   assign wr_fire   = aw_got_reg & w_got_reg & ~bvalid_reg;
   assign wr_idx    = aw_addr_reg[11:2];
   assign wr_mapped = (wr_idx >= `RUN_FLAG_IDX) && (wr_idx <= `HIGH_ONE_IDX);
   assign wr_take   = wr_fire & wr_mapped & w_lane_reg;

   // write response, unmapped index answers slave error
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= `RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // read side view of the run/flag register, low nibble reads zero
   assign timer_run_flag_reg = {overflow_flag_one_reg, run_bit_one_reg,
                                overflow_flag_zero_reg, run_bit_zero_reg, 4'h0};

   // read decode
   assign rd_idx = araddr[11:2];
   always_comb begin
      rd_byte   = 8'h00;
      rd_mapped = 1'b1;
      unique case (rd_idx)
         `RUN_FLAG_IDX:  rd_byte = timer_run_flag_reg;
         `MODE_IDX:      rd_byte = timer_mode_reg;
         `LOW_ZERO_IDX:  rd_byte = low_byte_zero_reg;
         `HIGH_ZERO_IDX: rd_byte = high_byte_zero_reg;
         `LOW_ONE_IDX:   rd_byte = low_byte_one_reg;
         `HIGH_ONE_IDX:  rd_byte = high_byte_one_reg;
         default:        rd_mapped = 1'b0;
      endcase
   end

   // read channel, data sampled at the address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= `RESP_OKAY;
         rdata_reg   <= 32'h0000_0000;
      end else begin
         arready_reg <= arvalid & ~arready_reg & ~rvalid_reg;
         if (arvalid && arready_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
            rdata_reg  <= {24'h00_0000, rd_byte};
         end else if (rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // mode register, both nibbles share one layout
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_mode_reg <= `MODE_RESET;
      end else if (wr_take && wr_idx == `MODE_IDX) begin
         timer_mode_reg <= w_byte_reg;
      end
   end

   assign mode_zero = timer_mode_type'(timer_mode_reg[`MODE_ZERO_HI:`MODE_ZERO_LO]);
   assign mode_one  = timer_mode_type'(timer_mode_reg[`MODE_ONE_HI:`MODE_ONE_LO]);
   assign split_zero = (mode_zero == MODE_SPLIT);

   // count enables: run bit, gate, then source select
   assign inc_zero = run_bit_zero_reg
                   & (~timer_mode_reg[`GATE_ZERO_BIT] | gate_lvl_zero)
                   & (timer_mode_reg[`SEL_ZERO_BIT] ? fall_zero : 1'b1);
   // split high byte counts machine cycles under the timer 1 run bit
   assign inc_zero_hi = split_zero & run_bit_one_reg;
   // timer 1 in its own split code just holds, like a cleared run bit
   assign inc_one = run_bit_one_reg
                  & (~timer_mode_reg[`GATE_ONE_BIT] | gate_lvl_one)
                  & (timer_mode_reg[`SEL_ONE_BIT] ? fall_one : 1'b1)
                  & (mode_one != MODE_SPLIT);

   count_step u_step_zero (
      .mode    (mode_zero),
      .lo      (low_byte_zero_reg),
      .hi      (high_byte_zero_reg),
      .inc_lo  (inc_zero),
      .inc_hi  (inc_zero_hi),
      .lo_next (lo_zero_next),
      .hi_next (hi_zero_next),
      .ovf_lo  (ovf_zero_lo),
      .ovf_hi  (ovf_zero_hi)
   );

   count_step u_step_one (
      .mode    (mode_one),
      .lo      (low_byte_one_reg),
      .hi      (high_byte_one_reg),
      .inc_lo  (inc_one),
      .inc_hi  (1'b0),
      .lo_next (lo_one_next),
      .hi_next (hi_one_next),
      .ovf_lo  (ovf_one_lo),
      .ovf_hi  ()
   );

   // count registers load their count step each machine cycle; a bus write wins
   // over the count step of the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_byte_zero_reg  <= `COUNT_RESET;
         high_byte_zero_reg <= `COUNT_RESET;
      end else begin
         if (wr_take && wr_idx == `LOW_ZERO_IDX) begin
            low_byte_zero_reg <= w_byte_reg;
         end else begin
            low_byte_zero_reg <= lo_zero_next;
         end
         if (wr_take && wr_idx == `HIGH_ZERO_IDX) begin
            high_byte_zero_reg <= w_byte_reg;
         end else begin
            high_byte_zero_reg <= hi_zero_next;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_byte_one_reg  <= `COUNT_RESET;
         high_byte_one_reg <= `COUNT_RESET;
      end else begin
         if (wr_take && wr_idx == `LOW_ONE_IDX) begin
            low_byte_one_reg <= w_byte_reg;
         end else begin
            low_byte_one_reg <= lo_one_next;
         end
         if (wr_take && wr_idx == `HIGH_ONE_IDX) begin
            high_byte_one_reg <= w_byte_reg;
         end else begin
            high_byte_one_reg <= hi_one_next;
         end
      end
   end

   // run bits touch nothing but themselves
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_bit_zero_reg <= 1'(`RUN_FLAG_RESET >> `RUN_ZERO_BIT);
         run_bit_one_reg  <= 1'(`RUN_FLAG_RESET >> `RUN_ONE_BIT);
      end else if (wr_take && wr_idx == `RUN_FLAG_IDX) begin
         run_bit_zero_reg <= w_byte_reg[`RUN_ZERO_BIT];
         run_bit_one_reg  <= w_byte_reg[`RUN_ONE_BIT];
      end
   end

   // in split mode the high byte of timer 0 owns the timer 1 flag
   assign set_flag_zero = ovf_zero_lo;
   assign set_flag_one  = split_zero ? ovf_zero_hi : ovf_one_lo;

   // overflow flags: hardware set beats a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         overflow_flag_zero_reg <= 1'b0;
         overflow_flag_one_reg  <= 1'b0;
      end else begin
         if (set_flag_zero) begin
            overflow_flag_zero_reg <= 1'b1;
         end else if (wr_take && wr_idx == `RUN_FLAG_IDX) begin
            overflow_flag_zero_reg <= w_byte_reg[`FLAG_ZERO_BIT];
         end else if (vector_ack_zero) begin
            overflow_flag_zero_reg <= 1'b0;
         end
         if (set_flag_one) begin
            overflow_flag_one_reg <= 1'b1;
         end else if (wr_take && wr_idx == `RUN_FLAG_IDX) begin
            overflow_flag_one_reg <= w_byte_reg[`FLAG_ONE_BIT];
         end else if (vector_ack_one) begin
            overflow_flag_one_reg <= 1'b0;
         end
      end
   end

   // timer 1 overflow reaches the serial side even when it has lost
   // its flag to the split high byte
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         baud_tick_reg <= 1'b0;
      end else begin
         baud_tick_reg <= ovf_one_lo;
      end
   end

   // outputs straight from flops
   assign awready   = awready_reg;
   assign wready    = wready_reg;
   assign bvalid    = bvalid_reg;
   assign bresp     = bresp_reg;
   assign arready   = arready_reg;
   assign rvalid    = rvalid_reg;
   assign rresp     = rresp_reg;
   assign rdata     = rdata_reg;
   assign irq_zero  = overflow_flag_zero_reg;
   assign irq_one   = overflow_flag_one_reg;
   assign baud_tick = baud_tick_reg;

endmodule

`default_nettype wire

/* test/timer_pair_checker.sv */
`timescale 1ns/10ps
`default_nettype none

module timer_pair_checker (
   input  wire logic        aclk,            // clock
   input  wire logic        aresetn,         // reset, low
   input  wire logic        awready,         // aw ready
   input  wire logic        wready,          // w ready
   input  wire logic [1:0]  bresp,           // b code
   input  wire logic        bvalid,          // b valid
   input  wire logic        bready,          // b ready
   input  wire logic        arready,         // ar ready
   input  wire logic [31:0] rdata,           // r data
   input  wire logic        rvalid,          // r valid
   input  wire logic        rready,          // r ready
   input  wire logic        vector_ack_zero, // ack 0
   input  wire logic        vector_ack_one,  // ack 1
   input  wire logic        irq_zero,        // request 0
   input  wire logic        irq_one          // request 1
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // a write is taken when both halves meet
   sequence s_wr_taken;
      awready && wready;
   endsequence
   sequence s_rd_taken;
      arready;
   endsequence

   AST_AW_PULSE: assert property (awready |=> !awready)
      else $error("awready held too long");
   AST_AR_PULSE: assert property (arready |=> !arready)
      else $error("arready held too long");
   // both halves land one edge after the handshake, the answer one edge later
   AST_WR_ANSWER: assert property (s_wr_taken |=> !awready ##1 bvalid)
      else $error("write answer late");
   AST_AW_BUSY: assert property (bvalid |-> !awready)
      else $error("write taken while busy");
   AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped");
   AST_RD_ANSWER: assert property (s_rd_taken |=> rvalid)
      else $error("read answer late");
   AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read answer dropped");
   AST_R_UPPER: assert property (rvalid |-> rdata[31:8] == 24'h0)
      else $error("upper read bits set");
   // a raised request stays until acked or rewritten
   AST_IRQ0_KEEP: assert property (
      irq_zero && !vector_ack_zero && !awready && !$past(awready) |=> irq_zero)
      else $error("request 0 lost");
   AST_IRQ1_KEEP: assert property (
      irq_one && !vector_ack_one && !awready && !$past(awready) |=> irq_one)
      else $error("request 1 lost");
endmodule

bind timer_pair timer_pair_checker u_chk (
   .aclk, .aresetn, .awready, .wready, .bresp, .bvalid, .bready, .arready,
   .rdata, .rvalid, .rready, .vector_ack_zero, .vector_ack_one, .irq_zero, .irq_one
);

`default_nettype wire

/* test/pin_model.sv */
`timescale 1ns/10ps
`default_nettype none

module pin_model (
   input  wire logic aclk,           // machine clock
   output logic      count_pin_zero, // event pin 0
   output logic      count_pin_one,  // event pin 1
   output logic      gate_pin_zero,  // gate pin 0
   output logic      gate_pin_one    // gate pin 1
);
   // event pins rest high so the first fall is real
   initial begin
      count_pin_zero = 1'b1;
      count_pin_one = 1'b1;
      gate_pin_zero = 1'b0;
      gate_pin_one = 1'b0;
   end

   // n falls, each level held two cycles so a sample always lands
   task automatic pulse(input int p, input int n);
      repeat (2 * n) begin
         @(posedge aclk);
         if (p == 0)
            count_pin_zero <= ~count_pin_zero;
         else
            count_pin_one <= ~count_pin_one;
         @(posedge aclk);
      end
   endtask

   // gate level, steady between calls
   task automatic gate(input int p, input logic l);
      @(posedge aclk);
      if (p == 0)
         gate_pin_zero <= l;
      else
         gate_pin_one <= l;
   endtask
endmodule

`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "timer_map.svh"

module tb_top;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        vector_ack_zero, vector_ack_one;
   logic        awready, wready, bvalid, arready, rvalid, irq_zero, irq_one, baud_tick;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp, r;
   logic [7:0]  d;
   wire         count_pin_zero, count_pin_one, gate_pin_zero, gate_pin_one;
   int          n_errors, checks, cyc, n_baud;

   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   timer_pair u_dut (
      .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
      .wstrb(4'h1), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .count_pin_zero, .count_pin_one, .gate_pin_zero, .gate_pin_one,
      .vector_ack_zero, .vector_ack_one, .irq_zero, .irq_one, .baud_tick
   );

   pin_model u_pins (
      .aclk, .count_pin_zero, .count_pin_one, .gate_pin_zero, .gate_pin_one
   );

   task automatic end_sim;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [9:0] g, input logic [9:0] e);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %0t got %h want %h", $time, g, e);
      end
   endtask

   // both halves offered together, each dropped when taken
   task automatic wr(input logic [9:0] i, input logic [7:0] v);
      @(posedge aclk);
      awaddr <= {i, 2'b00};
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      r = bresp;
   endtask

   task automatic rd(input logic [9:0] i);
      @(posedge aclk);
      araddr <= {i, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      r = rresp;
      d = rdata[7:0];
   endtask

   task automatic rc(input logic [9:0] i, input logic [7:0] e);
      rd(i);
      chk({r, d}, {`RESP_OKAY, e});
   endtask

   // preload a timer, start it, feed pin falls, compare bytes and flag
   task automatic seq(input int t, input logic [7:0] m, lo, hi, input int n,
                      input logic [7:0] elo, ehi, input logic f);
      logic [9:0] il;
      il = t ? `LOW_ONE_IDX : `LOW_ZERO_IDX;
      wr(`MODE_IDX, m);
      wr(il, lo);
      wr(il + 10'h1, hi);
      wr(`RUN_FLAG_IDX, t ? 8'h40 : 8'h10);
      u_pins.pulse(t, n);
      repeat (6) @(posedge aclk);
      rc(il, elo);
      rc(il + 10'h1, ehi);
      chk({9'h0, t ? irq_one : irq_zero}, {9'h0, f});
   endtask

   // baud pulses, one per timer 1 overflow
   always @(posedge aclk) begin
      if (baud_tick === 1'b1) n_baud <= n_baud + 1;
   end

   // hang guard, the run needs well under a thousand cycles
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_errors++;
         end_sim();
      end
   end

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
      {vector_ack_zero, vector_ack_one} = 2'h0;
      {awaddr, araddr, wdata} = 56'h0;
      {n_errors, checks, cyc, n_baud} = 128'h0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 'h88; i <= 'h8d; i++) rc(10'(i), 8'h00);
      // unmapped place answers with an error
      rd(10'h090);
      chk({r, d}, {`RESP_SLVERR, 8'h00});
      wr(10'h090, 8'h55);
      chk({r, 8'h00}, {`RESP_SLVERR, 8'h00});
      wr(`MODE_IDX, 8'h5a);
      rc(`MODE_IDX, 8'h5a);
      seq(0, 8'h05, 8'hfe, 8'hff, 3, 8'h01, 8'h00, 1'b1);
      vector_ack_zero <= 1'b1;
      @(posedge aclk);
      vector_ack_zero <= 1'b0;
      @(posedge aclk);
      chk({9'h0, irq_zero}, 10'h0);
      seq(0, 8'h04, 8'hff, 8'hff, 2, 8'he1, 8'h00, 1'b1);
      seq(0, 8'h06, 8'hfe, 8'hf0, 3, 8'hf1, 8'hf0, 1'b1);
      seq(0, 8'h0d, 8'h10, 8'h00, 2, 8'h10, 8'h00, 1'b0);
      u_pins.gate(0, 1'b1);
      seq(0, 8'h0d, 8'h10, 8'h00, 2, 8'h12, 8'h00, 1'b0);
      seq(1, 8'h70, 8'h00, 8'h00, 2, 8'h00, 8'h00, 1'b0);
      seq(1, 8'h50, 8'hff, 8'hff, 2, 8'h01, 8'h00, 1'b1);
      // split: high byte of timer 0 runs on the other run bit
      wr(`RUN_FLAG_IDX, 8'h00);
      wr(`MODE_IDX, 8'h07);
      wr(`HIGH_ZERO_IDX, 8'hfe);
      wr(`LOW_ZERO_IDX, 8'hff);
      wr(`RUN_FLAG_IDX, 8'h40);
      repeat (6) @(posedge aclk);
      chk({8'h0, irq_one, irq_zero}, 10'h2);
      vector_ack_one <= 1'b1;
      @(posedge aclk);
      vector_ack_one <= 1'b0;
      @(posedge aclk);
      chk({8'h0, irq_one, irq_zero}, 10'h0);
      wr(`RUN_FLAG_IDX, 8'h50);
      u_pins.pulse(0, 1);
      repeat (6) @(posedge aclk);
      chk({8'h0, irq_one, irq_zero}, 10'h1);
      chk(10'(n_baud), 10'h1);
      end_sim();
   end
endmodule

`default_nettype wire
